// ===== shared/rts_pkg.sv
/*
 * Constants, encodings and register map of the reset and start-up
 * time-out sequencer.
 * Assumes a single 125 MHz system clock; everything else is sampled on it.
 */
package rts_pkg;

    // Timing
    localparam int CLK_PERIOD_NS   = 8;
    localparam int POWERUP_DELAY_TIMER_MS         = 72;
    localparam int RC_TICK_KHZ     = 1000;
    localparam int OST_CYCLES      = 1024;
    localparam int PIN_FILT_NS     = 2000;
    localparam int BOR_FILT_NS     = 100000;
    localparam int PIN_FILT_CYC    = (PIN_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOR_FILT_CYC    = (BOR_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_DELAY_TIMER_TICKS      = POWERUP_DELAY_TIMER_MS * RC_TICK_KHZ;

    // Register byte offsets
    localparam logic [11:0] OFS_POWER_STATUS = 12'h000;
    localparam logic [11:0] OFS_CTRL         = 12'h004;
    localparam logic [11:0] OFS_SEQ_STATUS   = 12'h008;

    // Control register fields and reset value
    localparam int CTRL_POWERUP_DELAY_TIMER_EN_BIT = 0;
    localparam int CTRL_BOR_EN_BIT  = 1;
    localparam int CTRL_MODE_LSB    = 2;
    localparam logic [3:0] CTRL_RESET = 4'h3;

    // Power status fields
    localparam int PS_BROWNOUT_BIT = 0;
    localparam int PS_POWERON_BIT  = 1;

    // Sequence status fields
    localparam int SS_STATE_LSB = 0;
    localparam int SS_CAUSE_LSB = 4;
    localparam int SS_TO_BIT    = 8;
    localparam int SS_PD_BIT    = 9;
    localparam int SS_PIN_BIT   = 10;
    localparam int SS_LOW_BIT   = 11;

    typedef enum logic [1:0] {
        MODE_RC  = 2'b00,
        MODE_LP  = 2'b01,
        MODE_XT  = 2'b10,
        MODE_HS  = 2'b11
    } rts_mode_t;

    typedef enum logic [2:0] {
        ST_POWERUP_DELAY_TIMER     = 3'b000,
        ST_OST      = 3'b001,
        ST_RUN      = 3'b010,
        ST_BOR      = 3'b011,
        ST_SLEEP    = 3'b100,
        ST_WAKE_OST = 3'b101
    } rts_state_t;

    typedef enum logic [2:0] {
        CAUSE_POR       = 3'b000,
        CAUSE_PIN_RUN   = 3'b001,
        CAUSE_PIN_SLEEP = 3'b010,
        CAUSE_WDT_RUN   = 3'b011,
        CAUSE_BOR       = 3'b100,
        CAUSE_WDT_WAKE  = 3'b101
    } rts_cause_t;

endpackage

// ===== hw/rts_top.sv
/*
 * Reset and start-up time-out sequencer with an APB register slave.
 * Assumes all inputs synchronous to clk; rc_tick is a one-cycle strobe
 * from the internal RC oscillator, osc_in a sampled copy of the
 * oscillator input, slower than half the clk rate.
 */
`timescale 1ns/100ps

module rts_top #(
    parameter int POWERUP_DELAY_TIMER_TICKS    = rts_pkg::POWERUP_DELAY_TIMER_TICKS,
    parameter int OST_CYCLES    = rts_pkg::OST_CYCLES,
    parameter int PIN_FILT_CYC  = rts_pkg::PIN_FILT_CYC,
    parameter int BOR_FILT_CYC  = rts_pkg::BOR_FILT_CYC,
    parameter bit PIN_FILTER_EN = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        por_pulse,
    input  wire logic        supply_low,
    input  wire logic        ext_reset_n,
    input  wire logic        watchdog_reset,
    input  wire logic        watchdog_wake,
    input  wire logic        sleep_enter,
    input  wire logic        sleep_wake,
    input  wire logic        rc_tick,
    input  wire logic        osc_in,
    output logic             core_reset,
    output logic             core_hold,
    output logic             por_active,
    output logic             clock_div_out,
    output logic      [2:0]  reset_cause,
    output logic             timeout_flag,
    output logic             powerdown_flag
);

    rts_pkg::rts_state_t state_reg;
    rts_pkg::rts_state_t state_next;
    rts_pkg::rts_cause_t cause_reg;
    rts_pkg::rts_cause_t cause_next;

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic [31:0] pin_cnt_reg;
    logic [31:0] bor_cnt_reg;
    logic        pin_low_reg;
    logic        pin_low_d_reg;
    logic        bor_low_reg;
    logic        osc_prev_reg;
    logic        div_half_reg;
    logic        div_out_reg;
    logic        wdt_hold_reg;
    logic        to_reg;
    logic        to_next;
    logic        pd_reg;
    logic        pd_next;
    logic        ps_bor_reg;
    logic        ps_por_reg;
    logic [3:0]  ctrl_reg;
    logic [31:0] prdata_reg;

    // Decode of configuration and events
    wire         powerup_delay_timer_en    = ctrl_reg[rts_pkg::CTRL_POWERUP_DELAY_TIMER_EN_BIT];
    wire         bor_en     = ctrl_reg[rts_pkg::CTRL_BOR_EN_BIT];
    wire [1:0]   osc_mode   = ctrl_reg[rts_pkg::CTRL_MODE_LSB +: 2];
    wire         crystal    = osc_mode != rts_pkg::MODE_RC;
    wire         osc_rise   = osc_in & ~osc_prev_reg;
    wire         pin_low    = PIN_FILTER_EN ? pin_low_reg : ~ext_reset_n;
    wire         pin_fell   = pin_low & ~pin_low_d_reg;
    wire         powerup_delay_timer_done  = cnt_reg >= 32'(POWERUP_DELAY_TIMER_TICKS);
    wire         ost_done   = cnt_reg >= 32'(OST_CYCLES);
    wire         ev_bor     = bor_low_reg & (state_reg != rts_pkg::ST_BOR);
    wire         running    = state_reg == rts_pkg::ST_RUN;
    wire         sleeping   = state_reg == rts_pkg::ST_SLEEP;

    // Stage after power-up delay; brown-out recovery skips the count
    function automatic rts_pkg::rts_state_t after_powerup_delay_timer(input logic xtal,
                                                       input logic from_bor);
        if (xtal && !from_bor) begin
            after_powerup_delay_timer = rts_pkg::ST_OST;
        end else begin
            after_powerup_delay_timer = rts_pkg::ST_RUN;
        end
    endfunction

    // Sampled oscillator edge and divider
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_prev_reg <= 1'b0;
            div_half_reg <= 1'b0;
            div_out_reg  <= 1'b0;
        end else begin
            osc_prev_reg <= osc_in;
            if (osc_mode != rts_pkg::MODE_RC) begin
                div_half_reg <= 1'b0;
                div_out_reg  <= 1'b0;
            end else if (osc_rise) begin
                div_half_reg <= ~div_half_reg;
                div_out_reg  <= div_out_reg ^ div_half_reg;
            end
        end
    end

    // Pin glitch filter: low must persist before it counts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_cnt_reg   <= 32'h0000_0000;
            pin_low_reg   <= 1'b0;
            pin_low_d_reg <= 1'b0;
        end else begin
            pin_low_d_reg <= pin_low;
            if (ext_reset_n) begin
                pin_cnt_reg <= 32'h0000_0000;
                pin_low_reg <= 1'b0;
            end else if (pin_cnt_reg >= 32'(PIN_FILT_CYC - 1)) begin
                pin_low_reg <= 1'b1;
            end else begin
                pin_cnt_reg <= pin_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // Brown-out filter; short dips never reach the sequencer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bor_cnt_reg <= 32'h0000_0000;
            bor_low_reg <= 1'b0;
        end else if (!supply_low || !bor_en) begin
            bor_cnt_reg <= 32'h0000_0000;
            bor_low_reg <= 1'b0;
        end else if (bor_cnt_reg >= 32'(BOR_FILT_CYC - 1)) begin
            bor_low_reg <= 1'b1;
        end else begin
            bor_cnt_reg <= bor_cnt_reg + 32'h0000_0001;
        end
    end

    // Sequencer next state and cause; priority por > brown-out > pin > watchdog
    always_comb begin
        state_next = state_reg;
        cause_next = cause_reg;
        to_next    = to_reg;
        pd_next    = pd_reg;
        if (por_pulse) begin
            cause_next = rts_pkg::CAUSE_POR;
            to_next    = 1'b1;
            pd_next    = 1'b1;
            if (powerup_delay_timer_en) begin
                state_next = rts_pkg::ST_POWERUP_DELAY_TIMER;
            end else begin
                state_next = after_powerup_delay_timer(crystal, 1'b0);
            end
        end else if (ev_bor) begin
            state_next = rts_pkg::ST_BOR;
            cause_next = rts_pkg::CAUSE_BOR;
            to_next    = 1'b1;
            pd_next    = 1'b1;
        end else if (pin_fell && (running || sleeping)) begin
            state_next = rts_pkg::ST_RUN;
            if (sleeping) begin
                cause_next = rts_pkg::CAUSE_PIN_SLEEP;
                to_next    = 1'b1;
                pd_next    = 1'b0;
            end else begin
                cause_next = rts_pkg::CAUSE_PIN_RUN;
            end
        end else begin
            case (state_reg)
                rts_pkg::ST_POWERUP_DELAY_TIMER: begin
                    if (!powerup_delay_timer_en || powerup_delay_timer_done) begin
                        state_next = after_powerup_delay_timer(crystal,
                                                cause_reg == rts_pkg::CAUSE_BOR);
                    end
                end
                rts_pkg::ST_OST, rts_pkg::ST_WAKE_OST: begin
                    if (ost_done) begin
                        state_next = rts_pkg::ST_RUN;
                    end
                end
                rts_pkg::ST_BOR: begin
                    if (!supply_low) begin
                        state_next = powerup_delay_timer_en ? rts_pkg::ST_POWERUP_DELAY_TIMER : rts_pkg::ST_RUN;
                    end
                end
                rts_pkg::ST_RUN: begin
                    if (watchdog_reset) begin
                        cause_next = rts_pkg::CAUSE_WDT_RUN;
                        to_next    = 1'b0;
                        pd_next    = 1'b1;
                    end else if (sleep_enter) begin
                        state_next = rts_pkg::ST_SLEEP;
                        to_next    = 1'b1;
                        pd_next    = 1'b0;
                    end
                end
                rts_pkg::ST_SLEEP: begin
                    if (watchdog_wake || sleep_wake) begin
                        state_next = crystal ? rts_pkg::ST_WAKE_OST : rts_pkg::ST_RUN;
                        if (watchdog_wake) begin
                            cause_next = rts_pkg::CAUSE_WDT_WAKE;
                            to_next    = 1'b0;
                            pd_next    = 1'b0;
                        end
                    end
                end
                default: begin
                    state_next = rts_pkg::ST_POWERUP_DELAY_TIMER;
                end
            endcase
        end
    end

    // Shared time-out counter, cleared on every stage change
    always_comb begin
        cnt_next = cnt_reg;
        if (state_next != state_reg || por_pulse) begin
            cnt_next = 32'h0000_0000;
        end else if (state_reg == rts_pkg::ST_POWERUP_DELAY_TIMER && rc_tick && !powerup_delay_timer_done) begin
            cnt_next = cnt_reg + 32'h0000_0001;
        end else if ((state_reg == rts_pkg::ST_OST || state_reg == rts_pkg::ST_WAKE_OST)
                     && osc_rise && !ost_done) begin
            cnt_next = cnt_reg + 32'h0000_0001;
        end
    end

    // Sequencer registers; nrst release counts as a power-on
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= rts_pkg::ST_POWERUP_DELAY_TIMER;
            cause_reg    <= rts_pkg::CAUSE_POR;
            cnt_reg      <= 32'h0000_0000;
            to_reg       <= 1'b1;
            pd_reg       <= 1'b1;
            wdt_hold_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cause_reg    <= cause_next;
            cnt_reg      <= cnt_next;
            to_reg       <= to_next;
            pd_reg       <= pd_next;
            wdt_hold_reg <= running && watchdog_reset && !por_pulse && !ev_bor;
        end
    end

    // Core reset: sequence stages, filtered pin, internal watchdog pulse
    wire seq_hold = state_reg == rts_pkg::ST_POWERUP_DELAY_TIMER || state_reg == rts_pkg::ST_OST
                    || state_reg == rts_pkg::ST_BOR;
    assign core_reset     = seq_hold | pin_low | wdt_hold_reg | por_pulse;
    assign core_hold      = sleeping | (state_reg == rts_pkg::ST_WAKE_OST);
    assign por_active     = (cause_reg == rts_pkg::CAUSE_POR) & seq_hold;
    assign clock_div_out  = div_out_reg;
    assign reset_cause    = cause_reg;
    assign timeout_flag   = to_reg;
    assign powerdown_flag = pd_reg;

    // APB decode; the slave never waits
    wire setup    = psel & ~penable;
    wire access   = psel & penable;
    wire hit_ps   = paddr == rts_pkg::OFS_POWER_STATUS;
    wire hit_ctrl = paddr == rts_pkg::OFS_CTRL;
    wire hit_seq  = paddr == rts_pkg::OFS_SEQ_STATUS;
    wire mapped   = hit_ps | hit_ctrl | hit_seq;
    wire wr_ps    = access & pwrite & hit_ps;
    wire wr_ctrl  = access & pwrite & hit_ctrl;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_reg;

    // Read data captured in the setup cycle
    wire [31:0] rd_ps   = {30'h0, ps_por_reg, ps_bor_reg};
    wire [31:0] rd_ctrl = {28'h000_0000, ctrl_reg};
    wire [31:0] rd_seq  = {20'h0_0000, bor_low_reg, pin_low, pd_reg, to_reg,
                           1'b0, cause_reg, 1'b0, state_reg};
    wire [31:0] rd_mux  = hit_ps ? rd_ps : hit_ctrl ? rd_ctrl : hit_seq ? rd_seq
                          : 32'h0000_0000;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_reg <= 32'h0000_0000;
            ctrl_reg   <= rts_pkg::CTRL_RESET;
        end else begin
            if (setup) begin
                prdata_reg <= rd_mux;
            end
            if (wr_ctrl) begin
                ctrl_reg <= pwdata[3:0];
            end
        end
    end

    // Power-on status bit: cleared by power-on or by a software write of 0
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ps_por_reg <= 1'b0;
        end else if (por_pulse) begin
            ps_por_reg <= 1'b0;
        end else if (wr_ps) begin
            ps_por_reg <= pwdata[rts_pkg::PS_POWERON_BIT];
        end
    end

    // Brown-out status bit has no reset: unknown at power-on; hardware clear wins
    always_ff @(posedge clk) begin
        if (ev_bor) begin
            ps_bor_reg <= 1'b0;
        end else if (wr_ps) begin
            ps_bor_reg <= pwdata[rts_pkg::PS_BROWNOUT_BIT];
        end
    end

endmodule

// ===== testbench/rts_top_sva.sv
/* Port checker for the reset sequencer, bound into rts_top by the bench.
   Assumes one clock domain and the short filter widths set by the bench. */
`timescale 1ns/100ps
module rts_top_sva (
    input logic       clk,
    input logic       nrst,
    input logic       psel,
    input logic       penable,
    input logic [11:0] paddr,
    input logic       pready,
    input logic       pslverr,
    input logic       por_pulse,
    input logic       supply_low,
    input logic       ext_reset_n,
    input logic       watchdog_reset,
    input logic       watchdog_wake,
    input logic       core_reset,
    input logic       core_hold,
    input logic       por_active,
    input logic [2:0] reset_cause,
    input logic       timeout_flag,
    input logic       powerdown_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // No competing event, so a watchdog action shows undisturbed
    wire quiet = ext_reset_n && !supply_low && !por_pulse;
    wire run = quiet && !core_reset && !core_hold;
    wire mapped = paddr inside {12'h000, 12'h004, 12'h008};

    a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (psel && penable && mapped |-> pready && !pslverr)
        else $error("mapped access refused");
    a_por_reset: assert property (por_pulse |-> core_reset)
        else $error("power-on pulse without reset");
    a_por_flags: assert property (por_pulse |=> timeout_flag && powerdown_flag
        && reset_cause == rts_pkg::CAUSE_POR)
        else $error("power-on flags wrong");
    a_por_active: assert property (por_active |-> core_reset
        && reset_cause == rts_pkg::CAUSE_POR)
        else $error("power-on marker outside power-on hold");
    a_wdt_pulse: assert property (watchdog_reset && run |=> core_reset ##1 !core_reset)
        else $error("watchdog reset not one cycle");
    a_wdt_cause: assert property (watchdog_reset && run |=> !timeout_flag && powerdown_flag)
        else $error("watchdog flags wrong");
    a_wake_quiet: assert property (watchdog_wake && core_hold && !core_reset && quiet
        |=> !core_reset [*2])
        else $error("watchdog wake caused reset");
    a_pin_held: assert property (!ext_reset_n [*8] |-> core_reset)
        else $error("held pin not in reset");
    a_bor_stay: assert property ($past(core_reset) && $past(supply_low) && supply_low
        && reset_cause == rts_pkg::CAUSE_BOR |-> core_reset)
        else $error("left brown-out with supply low");
    a_cause_bor: assert property ($changed(reset_cause) && reset_cause == rts_pkg::CAUSE_BOR
        |-> $past(supply_low, 2) && $past(supply_low, 5))
        else $error("brown-out without long dip");
endmodule

// ===== testbench/rts_far.sv
/* Far-side model: supply monitors, reset pin and oscillator sources.
   Assumes its tasks are called from a process synchronised to clk. */
`timescale 1ns/100ps
module rts_far (
    input  logic clk,
    output logic por_pulse = 1'b0,
    output logic supply_low = 1'b0,
    output logic ext_reset_n = 1'b1,
    output logic rc_tick,
    output logic osc_in
);
    logic [2:0] div_q = 3'h0;
    // Free sources: RC strobe each 4 clocks, oscillator at clk/8
    always @(posedge clk) begin
        div_q <= div_q + 3'h1;
        rc_tick <= (div_q[1:0] == 2'h3);
        osc_in <= div_q[2];
    end
    // Supply rise, one clock wide
    task automatic por();
        @(posedge clk);
        por_pulse <= 1'b1;
        @(posedge clk);
        por_pulse <= 1'b0;
    endtask
    // Supply dip of n clocks
    task automatic low(input int n);
        @(posedge clk);
        supply_low <= 1'b1;
        repeat (n) @(posedge clk);
        supply_low <= 1'b0;
    endtask
    // Only this side drives the pin; the device never pulls it
    task automatic pin(input int n);
        @(posedge clk);
        ext_reset_n <= 1'b0;
        repeat (n) @(posedge clk);
        ext_reset_n <= 1'b1;
    endtask
endmodule

// ===== testbench/tb_reset_timeout_sequencer.sv
/* Self-checking bench for the reset and start-up time-out sequencer.
   Assumes rts_far stands on the supply, pin and oscillator side. */
`timescale 1ns/100ps
module tb_reset_timeout_sequencer;
    localparam int P = 20;
    localparam int O = 8;
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0]  ev = 4'h0;
    logic        pready, pslverr, e, por_pulse, supply_low, ext_reset_n, rc_tick, osc_in;
    logic        core_reset, core_hold, clock_div_out, timeout_flag, powerdown_flag, po, pd;
    logic        por_active;
    logic [2:0]  reset_cause;
    logic [7:0]  seed = 8'h24;
    logic [3:0]  cfg [6] = '{4'h3, 4'h7, 4'hb, 4'hf, 4'h0, 4'h8};
    int          errors = 0, n_checks = 0, cyc = 0, t, o, k;

    rts_top #(.POWERUP_DELAY_TIMER_TICKS(P), .OST_CYCLES(O), .PIN_FILT_CYC(4), .BOR_FILT_CYC(4))
        i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .por_pulse(por_pulse), .supply_low(supply_low),
        .ext_reset_n(ext_reset_n), .watchdog_reset(ev[0]), .watchdog_wake(ev[1]),
        .sleep_enter(ev[2]), .sleep_wake(ev[3]), .rc_tick(rc_tick), .osc_in(osc_in),
        .core_reset(core_reset), .core_hold(core_hold), .por_active(por_active),
        .clock_div_out(clock_div_out), .reset_cause(reset_cause),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
    rts_far i_far (.clk(clk), .por_pulse(por_pulse), .supply_low(supply_low),
        .ext_reset_n(ext_reset_n), .rc_tick(rc_tick), .osc_in(osc_in));

    // 125 MHz clock
    initial forever #4 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            summarize();
        end
    end

    task automatic summarize();
        if (errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask
    // One APB transfer; data and error taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev <= 4'h1 << i;
        @(posedge clk);
        ev <= 4'h0;
    endtask
    // RC strobes before the oscillator count, then oscillator rises, while held
    task automatic meas(input bit h, input int lim, input int et);
        int n = 0;
        t = 0;
        o = 0;
        po = osc_in;
        @(posedge clk);
        while ((h ? core_hold : core_reset) === 1'b1 && n < lim) begin
            if (supply_low === 1'b1) t = 0;
            else if (rc_tick === 1'b1 && o == 0) t++;
            if (t >= et && osc_in && !po) o++;
            po = osc_in;
            n++;
            @(posedge clk);
        end
        if (n == lim) errors++;
    endtask
    function automatic logic [31:0] near(input int g, input int x);
        return {31'h0, (g >= x - 2 && g <= x + 2)};
    endfunction
    function automatic int exp_t(input logic [3:0] c);
        return c[0] ? P : 0;
    endfunction
    function automatic int exp_o(input logic [3:0] c);
        return (c[3:2] != 2'h0) ? O : 0;
    endfunction
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        meas(1'b0, 5000, P);
        chk(near(t, P), 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(r, 32'h3);
        apb(1'b0, 12'h000, 32'h0);
        chk(r[1], 1'b0);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            apb(1'b1, 12'h000, {24'h0, seed});
            apb(1'b0, 12'h000, 32'h0);
            chk(r, {30'h0, seed[1:0]});
        end
        apb(1'b0, 12'h00c, 32'h0);
        chk({r[30:0], e}, 32'h1);
        apb(1'b1, 12'h000, 32'h3);
        t = 0;
        k = 0;
        for (int i = 0; i < 256; i++) begin
            po = osc_in;
            pd = clock_div_out;
            @(posedge clk);
            if (osc_in && !po) t++;
            if (clock_div_out && !pd) k++;
        end
        chk(near(k, t / 4), 32'h1);
        pulse(0);
        repeat (3) @(posedge clk);
        chk(reset_cause, rts_pkg::CAUSE_WDT_RUN);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h3);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            i_far.pin(int'(seed[1:0] % 2'd3) + 1);
            repeat (8) @(posedge clk);
            chk(core_reset, 1'b0);
        end
        i_far.pin(12);
        chk(reset_cause, rts_pkg::CAUSE_PIN_RUN);
        meas(1'b0, 500, 0);
        i_far.low(2);
        repeat (8) @(posedge clk);
        chk(core_reset, 1'b0);
        i_far.low(20);
        chk(reset_cause, rts_pkg::CAUSE_BOR);
        repeat (40) @(posedge clk);
        i_far.low(20);
        meas(1'b0, 5000, P);
        chk(near(t, P), 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h2);
        apb(1'b1, 12'h004, 32'h1);
        i_far.low(20);
        chk(core_reset, 1'b0);
        foreach (cfg[i]) begin
            apb(1'b1, 12'h004, {28'h0, cfg[i]});
            i_far.por();
            @(negedge clk);
            chk(por_active, exp_t(cfg[i]) != 0 || exp_o(cfg[i]) != 0);
            meas(1'b0, 5000, exp_t(cfg[i]));
            chk(near(t, exp_t(cfg[i])), 32'h1);
            chk(near(o, exp_o(cfg[i])), 32'h1);
            chk({timeout_flag, powerdown_flag, reset_cause}, 5'b11000);
            apb(1'b0, 12'h000, 32'h0);
            chk(r[1], 1'b0);
        end
        chk(clock_div_out, 1'b0);
        pulse(2);
        repeat (3) @(posedge clk);
        chk(core_hold, 1'b1);
        pulse(1);
        meas(1'b1, 5000, 0);
        chk(near(o, O), 32'h1);
        chk({reset_cause, timeout_flag, powerdown_flag}, 5'b10100);
        pulse(2);
        i_far.pin(12);
        chk(reset_cause, rts_pkg::CAUSE_PIN_SLEEP);
        meas(1'b0, 5000, 0);
        pulse(2);
        pulse(3);
        meas(1'b1, 5000, 0);
        chk(near(o, O), 32'h1);
        apb(1'b1, 12'h004, 32'h3);
        fork
            i_far.pin(P * 4 + 80);
            i_far.por();
            begin
                repeat (P * 4 + 60) @(posedge clk);
                chk(core_reset, 1'b1);
            end
        join
        meas(1'b0, 10, 0);
        apb(1'b0, 12'h008, 32'h0);
        chk(r, 32'h302);
        summarize();
    end
endmodule

bind rts_top rts_top_sva i_sva (.*);
